//--- logic/swr_pkg.sv
// constants, register map and wake source logic for the stop recovery and watchdog block
// Overview of operation
// - control bit 0 enables divide-by-16 clock prescaler
// - stop recovery clears the prescaler select bit
// - source codes 101..111 pick port-3 mixed logic
// - pins configured as outputs ignored by wake logic
// - reset loads source 000 and level low
// - either programmed source register can cause recovery
// - source register survives stop recovery, reset only
// - control bit 7 read-only, bits 6..0 write-only
// - watchdog one-shot resets cpu at terminal count
// - first dog instruction enables, later ones restart
// - watchdog counts on-chip rc oscillator ticks
// - dog instruction updates zero, sign, overflow flags
// - mode bits 1..0 select watchdog timeout tap
// - mode bit 2 halt run, bit 3 stop run
// - mode register writable only 120 clocks after reset, dog reset or recovery
// - mode register write-only at offset 0Fh
// - irq source pin or wake logic by mode bit
package swr_pkg;
	localparam logic [7:0] SWR_OFS_CTRL = 8'h0B;
	localparam logic [7:0] SWR_OFS_SRC2 = 8'h0D;
	localparam logic [7:0] SWR_OFS_DOG = 8'h0F;
	localparam int SWR_CTRL_PRESCALE_BIT = 0;
	localparam int SWR_SRC_LSB = 2;
	localparam int SWR_CTRL_LEVEL_BIT = 5;
	localparam int SWR_SRC2_LEVEL_BIT = 6;
	localparam int SWR_CTRL_RECOVERED_BIT = 7;
	localparam int SWR_DOG_HALT_BIT = 2;
	localparam int SWR_DOG_STOP_BIT = 3;
	localparam logic [2:0] SWR_SRC_RST = 3'h0;
	localparam logic [3:0] SWR_DOG_MODE_RST = 4'h0;
	localparam logic [2:0] SWR_ZSV_VALUE = 3'h0;
	localparam logic [3:0] SWR_PRESCALE_LAST = 4'hF;
	localparam logic [7:0] SWR_DOG_WIN_CYCLES = 8'h78;
	typedef enum {SWR_RUN, SWR_HALT, SWR_STOP} swr_power_t;

	// wake logic output for one source code; output pins drop out of the product
	function automatic logic swr_wake_out(input logic [2:0] code, input logic [7:0] p0,
			input logic [7:0] oe0, input logic [7:0] p2, input logic [7:0] oe2,
			input logic [3:1] p3);
		logic r;
		r = 1'b0;
		case (code)
			3'h1: r = ~&(p2[3:0] | oe2[3:0]);
			3'h2: r = ~&(p2 | oe2);
			3'h3: r = ~|p3;
			3'h4: r = ~&p3;
			3'h5: r = ~|{p3, p0[0] & ~oe0[0], p0[7] & ~oe0[7]};
			3'h6: r = ~&{p3, p0[0] | oe0[0], p0[7] | oe0[7]};
			3'h7: r = ~&{p3, p2[2:0] | oe2[2:0]};
			default: r = 1'b0;
		endcase
		return r;
	endfunction : swr_wake_out
endpackage : swr_pkg

//--- logic/swr_core.sv
// stop-mode recovery, clock prescaler and watchdog of the low-power controller
`timescale 1ns/100ps
module swr_core import swr_pkg::*; #(
	parameter logic [15:0] DOG_TC0 = 16'h0100,
	parameter logic [15:0] DOG_TC1 = 16'h0200,
	parameter logic [15:0] DOG_TC2 = 16'h0400,
	parameter logic [15:0] DOG_TC3 = 16'h1000
) (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	input wire logic [7:0] p0_i,
	input wire logic [7:0] p2_i,
	input wire logic [3:1] p3_i,
	input wire logic [7:0] p0_out_en_i,
	input wire logic [7:0] p2_out_en_i,
	input wire logic p3_analog_mode_i,
	input wire logic halt_mode_i,
	input wire logic stop_mode_i,
	input wire logic dog_instr_i,
	input wire logic rc_osc_i,
	output logic core_clk_en_o,
	output logic timer_clk_en_o,
	output logic stop_recovery_o,
	output logic dog_reset_o,
	output logic ext_irq_src_o,
	output logic flag_zsv_we_o,
	output logic [2:0] flag_zsv_o
);

	logic [7:0] p0_s1_reg, p0_s2_reg, p2_s1_reg, p2_s2_reg;
	logic [3:1] p3_s1_reg, p3_s2_reg;
	logic rc_s1_reg, rc_s2_reg, rc_prev_reg;
	logic rc_tick;

	logic ctrl_prescale_reg;
	logic [2:0] ctrl_src_reg;
	logic ctrl_level_reg;
	logic recovered_reg;
	logic [2:0] src2_code_reg;
	logic src2_level_reg;
	logic [3:0] dog_mode_reg;
	logic [7:0] win_cnt_reg;
	logic win_open;

	logic [3:0] pre_cnt_reg;
	logic dog_en_reg;
	logic [15:0] dog_cnt_reg;
	logic [15:0] dog_tc;
	logic dog_run;
	logic dog_fire;

	logic wake1, wake2, match1, match2, rec_event;
	swr_power_t power;

	logic wr_ctrl, wr_src2, wr_dog;

	assign wr_ctrl = reg_wr_i && reg_addr_i == SWR_OFS_CTRL;
	assign wr_src2 = reg_wr_i && reg_addr_i == SWR_OFS_SRC2;
	assign wr_dog = reg_wr_i && reg_addr_i == SWR_OFS_DOG;

	always_comb begin
		if (stop_mode_i) begin
			power = SWR_STOP;
		end else if (halt_mode_i) begin
			power = SWR_HALT;
		end else begin
			power = SWR_RUN;
		end
	end

	// pin synchronisers
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			p0_s1_reg <= 8'h00;
			p0_s2_reg <= 8'h00;
			p2_s1_reg <= 8'h00;
			p2_s2_reg <= 8'h00;
			p3_s1_reg <= 3'h0;
			p3_s2_reg <= 3'h0;
		end else begin
			p0_s1_reg <= p0_i;
			p0_s2_reg <= p0_s1_reg;
			p2_s1_reg <= p2_i;
			p2_s2_reg <= p2_s1_reg;
			p3_s1_reg <= p3_i;
			p3_s2_reg <= p3_s1_reg;
		end
	end

	// rc oscillator edge, sampled after two flops
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rc_s1_reg <= 1'b0;
			rc_s2_reg <= 1'b0;
			rc_prev_reg <= 1'b0;
		end else begin
			rc_s1_reg <= rc_osc_i;
			rc_s2_reg <= rc_s1_reg;
			rc_prev_reg <= rc_s2_reg;
		end
	end
	assign rc_tick = rc_s2_reg && !rc_prev_reg;

	// wake source logic for both recovery registers
	assign wake1 = swr_wake_out(ctrl_src_reg, p0_s2_reg, p0_out_en_i, p2_s2_reg,
		p2_out_en_i, p3_s2_reg);
	assign wake2 = swr_wake_out(src2_code_reg, p0_s2_reg, p0_out_en_i, p2_s2_reg,
		p2_out_en_i, p3_s2_reg);
	assign match1 = ctrl_src_reg != SWR_SRC_RST && wake1 == ctrl_level_reg;
	assign match2 = src2_code_reg != SWR_SRC_RST && wake2 == src2_level_reg;
	assign rec_event = power == SWR_STOP && (match1 || match2);

	// first recovery register
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ctrl_prescale_reg <= 1'b0;
			ctrl_src_reg <= SWR_SRC_RST;
			ctrl_level_reg <= 1'b0;
		end else if (rec_event) begin
			ctrl_prescale_reg <= 1'b0;
		end else if (wr_ctrl) begin
			ctrl_prescale_reg <= reg_wdata_i[SWR_CTRL_PRESCALE_BIT];
			ctrl_src_reg <= reg_wdata_i[SWR_SRC_LSB +: 3];
			ctrl_level_reg <= reg_wdata_i[SWR_CTRL_LEVEL_BIT];
		end
	end

	// recovered flag, hardware set only
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			recovered_reg <= 1'b0;
		end else if (rec_event) begin
			recovered_reg <= 1'b1;
		end
	end

	// second recovery register, untouched by recovery
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			src2_code_reg <= SWR_SRC_RST;
			src2_level_reg <= 1'b0;
		end else if (wr_src2) begin
			src2_code_reg <= reg_wdata_i[SWR_SRC_LSB +: 3];
			src2_level_reg <= reg_wdata_i[SWR_SRC2_LEVEL_BIT];
		end
	end

	// stop recovery pulse
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			stop_recovery_o <= 1'b0;
		end else begin
			stop_recovery_o <= rec_event;
		end
	end

	// write window after reset, dog reset or recovery
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			win_cnt_reg <= 8'h00;
		end else if (rec_event || dog_fire) begin
			win_cnt_reg <= 8'h00;
		end else if (win_open) begin
			win_cnt_reg <= win_cnt_reg + 8'h01;
		end
	end
	assign win_open = win_cnt_reg < SWR_DOG_WIN_CYCLES;

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			dog_mode_reg <= SWR_DOG_MODE_RST;
		end else if (wr_dog && win_open) begin
			dog_mode_reg <= reg_wdata_i[3:0];
		end
	end

	// register read, one cycle later
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_rd_i && reg_addr_i == SWR_OFS_CTRL) begin
			reg_rdata_o <= {recovered_reg, 7'h00};
		end else begin
			reg_rdata_o <= 8'h00;
		end
	end

	// divide-by-16 prescaler
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pre_cnt_reg <= 4'h0;
		end else begin
			pre_cnt_reg <= pre_cnt_reg + 4'h1;
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			core_clk_en_o <= 1'b0;
			timer_clk_en_o <= 1'b0;
		end else begin
			core_clk_en_o <= power == SWR_RUN && !rec_event &&
				(!ctrl_prescale_reg || pre_cnt_reg == SWR_PRESCALE_LAST);
			timer_clk_en_o <= power != SWR_STOP && !rec_event &&
				(!ctrl_prescale_reg || pre_cnt_reg == SWR_PRESCALE_LAST);
		end
	end

	// watchdog
	always_comb begin
		case (dog_mode_reg[1:0])
			2'h0: dog_tc = DOG_TC0;
			2'h1: dog_tc = DOG_TC1;
			2'h2: dog_tc = DOG_TC2;
			2'h3: dog_tc = DOG_TC3;
			default: dog_tc = DOG_TC0;
		endcase
	end

	always_comb begin
		case (power)
			SWR_RUN: dog_run = 1'b1;
			SWR_HALT: dog_run = dog_mode_reg[SWR_DOG_HALT_BIT];
			SWR_STOP: dog_run = dog_mode_reg[SWR_DOG_STOP_BIT];
			default: dog_run = 1'b0;
		endcase
	end

	assign dog_fire = dog_en_reg && dog_run && rc_tick && !dog_instr_i &&
		dog_cnt_reg >= dog_tc - 16'h0001;

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			dog_en_reg <= 1'b0;
		end else if (dog_instr_i) begin
			dog_en_reg <= 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			dog_cnt_reg <= 16'h0000;
		end else if (dog_instr_i || dog_fire) begin
			dog_cnt_reg <= 16'h0000;
		end else if (dog_en_reg && dog_run && rc_tick) begin
			dog_cnt_reg <= dog_cnt_reg + 16'h0001;
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			dog_reset_o <= 1'b0;
		end else begin
			dog_reset_o <= dog_fire;
		end
	end

	// flag update on dog instruction
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			flag_zsv_we_o <= 1'b0;
			flag_zsv_o <= 3'h0;
		end else begin
			flag_zsv_we_o <= dog_instr_i;
			flag_zsv_o <= SWR_ZSV_VALUE;
		end
	end

	// external interrupt source select
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ext_irq_src_o <= 1'b0;
		end else begin
			ext_irq_src_o <= p3_analog_mode_i ? wake1 : p3_s2_reg[3];
		end
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);

	a_prescale_clear: assert property (rec_event |=> !ctrl_prescale_reg && stop_recovery_o)
		else $error("prescaler select not cleared by recovery");
	a_prescale_rate: assert property (ctrl_prescale_reg && pre_cnt_reg != SWR_PRESCALE_LAST
			|=> !core_clk_en_o && !timer_clk_en_o)
		else $error("divided clock enable too frequent");
	a_src2_hold: assert property (rec_event && !wr_src2 |=> $stable(src2_code_reg)
			&& $stable(src2_level_reg))
		else $error("second source register changed by recovery");
	a_recover_stop: assert property (stop_recovery_o |-> $past(stop_mode_i)
			&& ($past(match1) || $past(match2)))
		else $error("recovery outside stop or without match");
	a_ctrl_read: assert property (reg_rd_i && reg_addr_i == SWR_OFS_CTRL
			|=> reg_rdata_o == {$past(recovered_reg), 7'h00})
		else $error("control readback wrong");
	a_dog_read: assert property (reg_rd_i && reg_addr_i == SWR_OFS_DOG
			|=> reg_rdata_o == 8'h00)
		else $error("mode register readable");
	a_dog_lock: assert property (!win_open && wr_dog |=> $stable(dog_mode_reg))
		else $error("mode register written after window");
	// window closes after its last open cycle unless restarted
	a_win_len: assert property (win_cnt_reg == SWR_DOG_WIN_CYCLES - 8'h01 && !rec_event
			&& !dog_fire |=> !win_open)
		else $error("write window length wrong");
	a_win_step: assert property (win_open && !rec_event && !dog_fire
			|=> win_cnt_reg == $past(win_cnt_reg) + 8'h01)
		else $error("write window count skipped");
	a_dog_kick: assert property (dog_instr_i |=> dog_en_reg && dog_cnt_reg == 16'h0000
			&& flag_zsv_we_o)
		else $error("dog instruction did not restart");
	a_dog_fire: assert property (dog_reset_o |-> $past(dog_en_reg) && $past(rc_tick)
			&& $past(dog_cnt_reg) == dog_tc - 16'h0001 && dog_cnt_reg == 16'h0000)
		else $error("dog reset not at terminal count");
	a_irq_src: assert property (##1 ext_irq_src_o == ($past(p3_analog_mode_i)
			? $past(wake1) : $past(p3_s2_reg[3])))
		else $error("irq source select wrong");

endmodule : swr_core

//--- tb/test_stop_recovery_and_watchdog.sv
// self-checking bench for the stop recovery and watchdog block
`timescale 1ns/100ps
module test_stop_recovery_and_watchdog import swr_pkg::*; ;
	logic clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
	logic reg_wr_i = 1'b0, reg_rd_i = 1'b0;
	logic [7:0] p0_i = 8'h00, p2_i = 8'h00, p0_out_en_i = 8'h00, p2_out_en_i = 8'h00;
	logic [3:1] p3_i = 3'h0;
	logic p3_analog_mode_i = 1'b0, halt_mode_i = 1'b0, stop_mode_i = 1'b0;
	logic dog_instr_i = 1'b0, rc_osc_i = 1'b0;
	logic core_clk_en_o, timer_clk_en_o, stop_recovery_o, dog_reset_o, ext_irq_src_o;
	logic flag_zsv_we_o;
	logic [2:0] flag_zsv_o;
	int err_total = 0, cmp_count = 0, tmo = 0, rec_n = 0, dog_n = 0, old;
	// pin patterns and expected wake output per code (bit index = code)
	logic [7:0] pa0 [3] = '{8'h00, 8'h81, 8'h81};
	logic [7:0] po0 [3] = '{8'h00, 8'h00, 8'h81};
	logic [7:0] pa2 [3] = '{8'h0F, 8'hF0, 8'h00};
	logic [7:0] po2 [3] = '{8'h00, 8'h00, 8'hFF};
	logic [2:0] pa3 [3] = '{3'h7, 3'h0, 3'h0};
	logic [7:0] wexp [3] = '{8'h44, 8'hDE, 8'hF8};

	swr_core #(.DOG_TC0(16'h0004), .DOG_TC1(16'h0008), .DOG_TC2(16'h0010),
		.DOG_TC3(16'h0020)) dut (.clk_i(clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .p0_i(p0_i), .p2_i(p2_i), .p3_i(p3_i),
		.p0_out_en_i(p0_out_en_i), .p2_out_en_i(p2_out_en_i),
		.p3_analog_mode_i(p3_analog_mode_i), .halt_mode_i(halt_mode_i),
		.stop_mode_i(stop_mode_i), .dog_instr_i(dog_instr_i), .rc_osc_i(rc_osc_i),
		.core_clk_en_o(core_clk_en_o), .timer_clk_en_o(timer_clk_en_o),
		.stop_recovery_o(stop_recovery_o), .dog_reset_o(dog_reset_o),
		.ext_irq_src_o(ext_irq_src_o), .flag_zsv_we_o(flag_zsv_we_o),
		.flag_zsv_o(flag_zsv_o));

	always #2 clk_i = ~clk_i;

	always @(posedge clk_i) begin
		if (stop_recovery_o === 1'b1) rec_n++;
		if (dog_reset_o === 1'b1) dog_n++;
		tmo++;
		if (tmo == 20000) begin
			err_total++;
			end_sim();
		end
	end

	task automatic end_sim();
		if (err_total == 0 && cmp_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : end_sim

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask : cyc

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		#1 chk(reg_rdata_o, exp);
	endtask : rd

	task automatic tick(input int n);
		repeat (n) begin
			@(posedge clk_i) rc_osc_i <= 1'b1;
			cyc(4);
			rc_osc_i <= 1'b0;
			cyc(4);
		end
	endtask : tick

	task automatic dog_kick();
		@(posedge clk_i) dog_instr_i <= 1'b1;
		@(posedge clk_i) dog_instr_i <= 1'b0;
		#1 chk(flag_zsv_we_o, 8'h01);
		chk(flag_zsv_o, 8'h00);
	endtask : dog_kick

	task automatic en_count(input int n, input int exp);
		int c;
		c = 0;
		repeat (n) begin
			@(posedge clk_i);
			#1 if (core_clk_en_o === 1'b1) c++;
		end
		chk(8'(c), 8'(exp));
	endtask : en_count

	initial begin
		cyc(6);
		resetn_i <= 1'b1;
		wr(SWR_OFS_DOG, 8'h00);
		rd(SWR_OFS_CTRL, 8'h00);
		rd(SWR_OFS_SRC2, 8'h00);
		rd(SWR_OFS_DOG, 8'h00);
		rd(8'h20, 8'h00);
		wr(SWR_OFS_CTRL, 8'h01);
		cyc(2);
		en_count(32, 2);
		p3_analog_mode_i <= 1'b1;
		for (int k = 0; k < 3; k++) begin
			p0_i <= pa0[k];
			p0_out_en_i <= po0[k];
			p2_i <= pa2[k];
			p2_out_en_i <= po2[k];
			p3_i <= pa3[k];
			for (int c = 0; c < 8; c++) begin
				wr(SWR_OFS_CTRL, {3'h0, 3'(c), 2'h0});
				cyc(5);
				chk(ext_irq_src_o, wexp[k][c]);
			end
		end
		p3_analog_mode_i <= 1'b0;
		p3_i <= 3'h4;
		cyc(5);
		chk(ext_irq_src_o, 8'h01);
		// window long closed: tap 3 must not take
		wr(SWR_OFS_DOG, 8'h03);
		old = dog_n;
		dog_kick();
		tick(3);
		dog_kick();
		tick(3);
		chk(8'(dog_n - old), 8'h00);
		tick(1);
		cyc(6);
		chk(8'(dog_n - old), 8'h01);
		wr(SWR_OFS_DOG, 8'h01);
		dog_kick();
		halt_mode_i <= 1'b1;
		tick(8);
		chk(8'(dog_n - old), 8'h01);
		chk(core_clk_en_o, 8'h00);
		chk(timer_clk_en_o, 8'h01);
		halt_mode_i <= 1'b0;
		tick(7);
		chk(8'(dog_n - old), 8'h01);
		tick(1);
		cyc(6);
		chk(8'(dog_n - old), 8'h02);
		// stop recovery through the second register, level high
		p2_out_en_i <= 8'h00;
		p2_i <= 8'h0F;
		wr(SWR_OFS_SRC2, 8'h44);
		wr(SWR_OFS_CTRL, 8'h01);
		stop_mode_i <= 1'b1;
		old = rec_n;
		cyc(8);
		chk(8'(rec_n - old), 8'h00);
		chk(timer_clk_en_o, 8'h00);
		p2_i <= 8'h0E;
		for (int i = 0; i < 12 && rec_n == old; i++) cyc(1);
		stop_mode_i <= 1'b0;
		chk(8'(rec_n > old), 8'h01);
		rd(SWR_OFS_CTRL, 8'h80);
		cyc(2);
		en_count(16, 16);
		old = rec_n;
		stop_mode_i <= 1'b1;
		for (int i = 0; i < 12 && rec_n == old; i++) cyc(1);
		stop_mode_i <= 1'b0;
		chk(8'(rec_n > old), 8'h01);
		end_sim();
	end
endmodule : test_stop_recovery_and_watchdog
